//--- core/pmac_ctl.sv
// Chosen here: the address map and the address-and-strobe port.
`include "pmac_regs.svh"
module pmac_ctl #(
	parameter int ROM_DEPTH = 256,
	parameter int AW = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Host register port
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// Data memory
	output logic [AW-1:0] memAddr,
	output logic memHostSel,
	input wire logic [15:0] memRdata,
	// Datapath side
	pmac_if.ctl link
);
	// ----------------------------------------
	// Microcode store and sequencer
	// ----------------------------------------
	logic [15:0] rom [ROM_DEPTH];
	logic [AW-1:0] startLatch;
	logic [AW-1:0] pc;
	logic [15:0] pipe;
	logic [15:0] capture;
	logic [15:0] romWord;
	logic doneFlag;
	logic ovfFlag;
	logic go;
	logic wrStart;
	logic wrCtrl;
	logic wrDataAddr;
	logic wrRom;
	logic [15:0] runLen;
	pmac_pkg::pmac_seq_t state;
	// Idle word: bit five high keeps the datapath off the bus
	localparam logic [15:0] NOP_WORD = {8'h0, `PMAC_OP_NOP};

	assign romWord = rom[pc];

	// ----------------------------------------
	// Host write decode
	// ----------------------------------------
	// One strobe per register keeps the address compares in one place
	assign wrStart = regWr && regAddr == `PMAC_REG_START;
	assign wrCtrl = regWr && regAddr == `PMAC_REG_CTRL;
	assign wrDataAddr = regWr && regAddr == `PMAC_REG_DATA_ADDR;
	assign wrRom = regWr && regAddr == `PMAC_REG_ROM;
	// GO is a pulse; nothing holds it, so a later write restarts cleanly
	assign go = wrCtrl && regWdata[`PMAC_CTRL_GO_BIT];

	// ----------------------------------------
	// Microcode loading and host registers
	// ----------------------------------------
	// Host loads words at the start latch address; no reset, the store acts as RAM
	always_ff @(posedge clk) begin
		if (clkEn && wrRom) begin
			rom[startLatch] <= regWdata;
		end
	end

	// Host latch and memory owner select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startLatch <= AW'(`PMAC_START_RST);
			memHostSel <= 1'b1;
		end else if (clkEn) begin
			if (wrStart) begin
				startLatch <= regWdata[AW-1:0];
			end
			if (wrCtrl) begin
				memHostSel <= regWdata[`PMAC_CTRL_HOSTMEM_BIT];
			end
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Counter preload, stepping, and pipeline latch; a word fetched now runs next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= pmac_pkg::PMAC_SEQ_IDLE;
			pc <= '0;
			pipe <= NOP_WORD;
		end else if (clkEn) begin
			unique case (state)
				pmac_pkg::PMAC_SEQ_IDLE: begin
					pipe <= NOP_WORD;
					if (go) begin
						pc <= startLatch;
						state <= pmac_pkg::PMAC_SEQ_RUN;
					end
				end
				pmac_pkg::PMAC_SEQ_RUN: begin
					pipe <= romWord;
					pc <= pc + AW'(1);
					if (romWord[`PMAC_ROM_END_BIT]) begin
						state <= pmac_pkg::PMAC_SEQ_DRAIN;
					end
				end
				pmac_pkg::PMAC_SEQ_DRAIN: begin
					pipe <= NOP_WORD;
					state <= pmac_pkg::PMAC_SEQ_IDLE;
				end
				// The unused fourth code of the state falls back to idle
				default: begin
					pipe <= NOP_WORD;
					state <= pmac_pkg::PMAC_SEQ_IDLE;
				end
			endcase
		end
	end

	// Cycles spent in the last routine, cleared by GO, stopped by the end bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			runLen <= 16'h0;
		end else if (clkEn) begin
			if (go && state == pmac_pkg::PMAC_SEQ_IDLE) begin
				runLen <= 16'h0;
			end else if (state == pmac_pkg::PMAC_SEQ_RUN) begin
				runLen <= runLen + 16'h1;
			end
		end
	end

	// ----------------------------------------
	// Data memory addressing
	// ----------------------------------------
	// Data address counter, separate from the program counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memAddr <= '0;
		end else if (clkEn) begin
			if (wrDataAddr) begin
				memAddr <= regWdata[AW-1:0];
			end else if (pipe[`PMAC_ROM_DINC_BIT]) begin
				memAddr <= memAddr + AW'(1);
			end
		end
	end

	// ----------------------------------------
	// Status and capture
	// ----------------------------------------
	// Status flags: set wins over host clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			doneFlag <= 1'b0;
			ovfFlag <= 1'b0;
			capture <= 16'h0;
		end else if (clkEn) begin
			if (state == pmac_pkg::PMAC_SEQ_DRAIN) begin
				doneFlag <= 1'b1;
			end else if (go) begin
				doneFlag <= 1'b0;
			end
			if (link.overflow) begin
				ovfFlag <= 1'b1;
			end else if (go) begin
				ovfFlag <= 1'b0;
			end
			if (pipe[`PMAC_ROM_CAP_BIT] && link.busFromMacEn) begin
				capture <= link.busFromMac;
			end
		end
	end

	// ----------------------------------------
	// Register read-back
	// ----------------------------------------
	// Register read, data one cycle after strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 16'h0;
		end else if (clkEn) begin
			regRdata <= 16'h0;
			if (regRd) begin
				unique case (regAddr)
					`PMAC_REG_START: regRdata <= 16'(startLatch);
					`PMAC_REG_CTRL: regRdata <= {14'h0, memHostSel, 1'b0};
					`PMAC_REG_STATUS: regRdata <= {13'h0, state != pmac_pkg::PMAC_SEQ_IDLE,
						ovfFlag, doneFlag};
					`PMAC_REG_DATA_ADDR: regRdata <= 16'(memAddr);
					`PMAC_REG_CAPTURE: regRdata <= capture;
					`PMAC_REG_RUNLEN: regRdata <= runLen;
					default: regRdata <= 16'h0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Link drive
	// ----------------------------------------
	// Pipeline word low byte is the datapath instruction
	assign link.insn = pipe[7:0];
	// Data memory reaches the datapath bus without a stage
	assign link.busToMac = memRdata;
endmodule // pmac_ctl

//--- core/pmac_if.sv
`include "pmac_regs.svh"
interface pmac_if;
	logic [`PMAC_INSN_W-1:0] insn;
	logic [15:0] busToMac;
	logic [15:0] busFromMac;
	logic busFromMacEn;
	logic overflow;
	modport mac (
		input insn,
		input busToMac,
		output busFromMac,
		output busFromMacEn,
		output overflow
	);
	modport ctl (
		output insn,
		output busToMac,
		input busFromMac,
		input busFromMacEn,
		input overflow
	);
endinterface

//--- core/pmac_mac.sv
`include "pmac_regs.svh"
module pmac_mac (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Controller side
	pmac_if.mac link,
	// Observation
	output logic [39:0] accum
);
	// ----------------------------------------
	// Datapath state
	// ----------------------------------------
	logic [15:0] opX;
	logic [15:0] opY;
	logic [7:0] accTop;
	logic [15:0] accUp;
	logic [15:0] accLow;
	logic [39:0] product;
	logic [1:0] mulCtl;
	logic mulRun;
	logic [31:0] rawProd;
	logic [39:0] next_prod;
	logic [`PMAC_INSN_W-1:0] op;
	logic isMul;
	logic isOut;
	logic [15:0] outWord;
	logic [15:0] outVal;
	logic ovf;

	assign op = link.insn;
	assign isMul = op == `PMAC_OP_MUL || op == `PMAC_OP_MAC || op == `PMAC_OP_MSUB;
	assign isOut = !op[`PMAC_BIT_NOOUT];
	assign rawProd = $signed(opX) * $signed(opY);

	// Product pipeline: operands captured at presenting edge, result one stage on
	always_comb begin
		next_prod = {{8{rawProd[31]}}, rawProd};
		unique case (mulCtl)
			2'h1: next_prod = {accTop, accUp, accLow} + {{8{rawProd[31]}}, rawProd};
			2'h2: next_prod = {accTop, accUp, accLow} - {{8{rawProd[31]}}, rawProd};
			default: next_prod = {{8{rawProd[31]}}, rawProd};
		endcase
	end

	// Multiplier controls latched for the execution cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mulCtl <= 2'h0;
			mulRun <= 1'b0;
			product <= 40'h0;
		end else if (clkEn) begin
			mulRun <= isMul;
			if (isMul) begin
				mulCtl <= (op == `PMAC_OP_MAC) ? 2'h1 : (op == `PMAC_OP_MSUB) ? 2'h2 : 2'h0;
			end
			if (mulRun) begin
				product <= next_prod;
			end
		end
	end

	// Operand registers; loading first operand never disturbs a running multiply
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			opX <= 16'h0;
			opY <= 16'h0;
		end else if (clkEn) begin
			if (op == `PMAC_OP_LD_X && !mulRun) begin
				opX <= link.busToMac;
			end else if (op == `PMAC_OP_LD_X) begin
				opX <= link.busToMac;
			end
			if (isMul) begin
				opY <= link.busToMac;
			end
		end
	end

	// Accumulator registers, 40 bits in three parts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			accTop <= 8'h0;
			accUp <= 16'h0;
			accLow <= 16'h0;
		end else if (clkEn) begin
			unique case (op)
				`PMAC_OP_STROBE, `PMAC_OP_MUL, `PMAC_OP_MAC, `PMAC_OP_MSUB: begin
					{accTop, accUp, accLow} <= product;
				end
				`PMAC_OP_LD_LOW: accLow <= link.busToMac;
				`PMAC_OP_LD_UP: accUp <= link.busToMac;
				`PMAC_OP_LD_TOP: accTop <= link.busToMac[7:0];
				`PMAC_OP_MV_LOW_UP: accUp <= accLow;
				`PMAC_OP_MV_TOP_UP: accUp <= {{8{accTop[7]}}, accTop};
				`PMAC_OP_SX_UP_TOP: accTop <= {8{accUp[15]}};
				`PMAC_OP_SX_LOW_UP: accUp <= {16{accLow[15]}};
				default: accTop <= accTop;
			endcase
		end
	end

	// Overflow when top byte is not the sign extension of the upper word
	assign ovf = accTop != {8{accUp[15]}};

	// Output class: combinational from the current accumulator registers, whatever last loaded them
	always_comb begin
		outWord = accLow;
		unique case (op[1:0])
			2'h0: outWord = {{8{accTop[7]}}, accTop};
			2'h1: outWord = op[`PMAC_OUT_SL_BIT] ? {accUp[14:0], accLow[15]} : accUp;
			default: outWord = op[`PMAC_OUT_SL_BIT] ? {accLow[14:0], 1'b0} : accLow;
		endcase
		outVal = outWord;
		if (op[`PMAC_OUT_SAT_BIT] && ovf) begin
			outVal = accTop[7] ? 16'h8000 : 16'h7fff;
		end
	end

	// Drive straight from the instruction so data holds all cycle
	assign link.busFromMac = isOut ? outVal : 16'h0;
	assign link.busFromMacEn = isOut;
	assign link.overflow = ovf;
	assign accum = {accTop, accUp, accLow};
endmodule // pmac_mac

//--- core/pmac_pkg.sv
package pmac_pkg;
	typedef enum logic [1:0] {
		PMAC_SEQ_IDLE,
		PMAC_SEQ_RUN,
		PMAC_SEQ_DRAIN
	} pmac_seq_t;
endpackage

//--- core/pmac_regs.svh
// Behaviour
// - Register loads take effect at cycle end.
// - Load class: strobe, bus loads, moves, sign extends.
// - Outputs drive bus within presenting cycle.
// - Output top, upper or lower, shift/clamp options.
// - Output data stable for capture at edge.
// - Multiply starts next cycle, needs two cycles.
// - Multiply also loads second operand, strobes accumulator.
// - Multiply strobe takes previous product; controls latched.
// - First operand load never disturbs running multiply.
// - Later strobe adds new product to accumulator.
// - Controller presents instructions from pipeline register.
// - Next address computed, fetched, latched at edge.
// - Binary counter steps ROM, output latched.
// - Separate counter addresses data memory.
// - Program counter preloadable with routine start.
// - ROM end bit marks routine finished.
// - Host latch holds start address for preload.
// - Overflow and end bit in host status.
// - Control register selects memory owner mux.
// - Accumulator is 40 bits: top, upper, lower.
// - Bit five high means never driving bus.
// - Clamp saturates output on overflow.
`ifndef PMAC_REGS_SVH
`define PMAC_REGS_SVH
// ----------------------------------------
// Instruction encoding
// ----------------------------------------
`define PMAC_INSN_W 8
`define PMAC_BIT_NOOUT 5
`define PMAC_OP_NOP 8'h20
`define PMAC_OP_STROBE 8'h21
`define PMAC_OP_LD_X 8'h22
`define PMAC_OP_LD_LOW 8'h23
`define PMAC_OP_LD_UP 8'h24
`define PMAC_OP_LD_TOP 8'h25
`define PMAC_OP_MV_LOW_UP 8'h26
`define PMAC_OP_MV_TOP_UP 8'h27
`define PMAC_OP_SX_UP_TOP 8'h28
`define PMAC_OP_SX_LOW_UP 8'h29
`define PMAC_OP_MUL 8'h2a
`define PMAC_OP_MAC 8'h2b
`define PMAC_OP_MSUB 8'h2c
`define PMAC_OP_OUT_TOP 8'h00
`define PMAC_OP_OUT_UP 8'h01
`define PMAC_OP_OUT_LOW 8'h02
`define PMAC_OUT_SL_BIT 2
`define PMAC_OUT_SAT_BIT 3
// ----------------------------------------
// Controller register map
// ----------------------------------------
`define PMAC_REG_START 4'h0
`define PMAC_REG_CTRL 4'h1
`define PMAC_REG_STATUS 4'h2
`define PMAC_REG_DATA_ADDR 4'h3
`define PMAC_REG_CAPTURE 4'h4
`define PMAC_REG_ROM 4'h5
`define PMAC_REG_RUNLEN 4'h6
`define PMAC_CTRL_GO_BIT 0
`define PMAC_CTRL_HOSTMEM_BIT 1
`define PMAC_ROM_END_BIT 8
`define PMAC_ROM_DINC_BIT 9
`define PMAC_ROM_CAP_BIT 10
`define PMAC_START_RST 8'h00
`endif

//--- dv/pmac_properties.sv
`include "pmac_regs.svh"
module pmac_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link signals
	input wire logic [`PMAC_INSN_W-1:0] insn,
	input wire logic [15:0] busToMac,
	input wire logic [15:0] busFromMac,
	input wire logic busFromMacEn,
	input wire logic overflow
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] prevBus;
	logic [15:0] prevBus2;
	// ----------------------------------------
	// Bus history
	// ----------------------------------------
	// Loads are tied to later outputs through this history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prevBus <= 16'h0000;
			prevBus2 <= 16'h0000;
		end else begin
			prevBus <= busToMac;
			prevBus2 <= prevBus;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_drive_bit_five: assert property (busFromMacEn == !insn[`PMAC_BIT_NOOUT])
		else $error("drive enable wrong");
	a_quiet_bus: assert property (!busFromMacEn |-> busFromMac == 16'h0000)
		else $error("idle bus not zero");
	a_load_upper_seen: assert property ((insn == `PMAC_OP_LD_UP) ##1 (insn == `PMAC_OP_OUT_UP)
		|-> busFromMac == prevBus) else $error("upper load not seen");
	a_shift_lower: assert property ((insn == `PMAC_OP_LD_LOW) ##1 (insn == 8'h06)
		|-> busFromMac == {prevBus[14:0], 1'b0}) else $error("shift output wrong");
	a_move_low_up: assert property ((insn == `PMAC_OP_LD_LOW) ##1 (insn == `PMAC_OP_MV_LOW_UP)
		##1 (insn == `PMAC_OP_OUT_UP) |-> busFromMac == prevBus2) else $error("move wrong");
	a_sat_upper: assert property ((insn == 8'h09 && overflow)
		|-> busFromMac inside {16'h7fff, 16'h8000}) else $error("no saturation");
	a_out_steady: assert property ((insn == `PMAC_OP_OUT_UP) ##1 (insn == `PMAC_OP_OUT_UP)
		|-> $stable(busFromMac)) else $error("output moved without strobe");
	a_sext_top: assert property ((insn == `PMAC_OP_SX_UP_TOP) |=> !overflow)
		else $error("overflow after sign extend");
endmodule // pmac_properties

//--- dv/pmac_tb_top.sv
`include "pmac_regs.svh"
module pmac_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdata;
	logic [7:0] memAddr;
	logic memHostSel;
	logic [15:0] memRdata;
	logic [39:0] accum;
	logic [39:0] prod;
	logic [15:0] status;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	// Routines at 0, 8, 14 and 17: {capture, step, end, instruction}
	logic [15:0] image [0:26] = '{16'h0022, 16'h022a, 16'h0022, 16'h002b, 16'h0020,
		16'h0021, 16'h0001, 16'h0501, 16'h0022, 16'h002a, 16'h0020, 16'h002c, 16'h0020,
		16'h0121, 16'h0025, 16'h0409, 16'h0100, 16'h0023, 16'h0006, 16'h0023, 16'h0026,
		16'h0001, 16'h0024, 16'h0401, 16'h0028, 16'h0027, 16'h0129};
	pmac_if link();
	// Memory word carries its address; low byte 05 is what a top-byte load takes, forcing overflow
	assign memRdata = {memAddr, 8'h05};
	pmac_mac pmac_mac_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .link(link), .accum(accum));
	pmac_ctl pmac_ctl_i (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.memAddr(memAddr), .memHostSel(memHostSel), .memRdata(memRdata), .link(link));
	pmac_properties pmac_properties_i (.clk(clk), .rst_n(rst_n), .insn(link.insn),
		.busToMac(link.busToMac), .busFromMac(link.busFromMac),
		.busFromMacEn(link.busFromMacEn), .overflow(link.overflow));
	// ----------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------
	always #2 clk = ~clk;
	// A hung sequencer would otherwise stall the run forever
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk40(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Strobes drop for one cycle so no signal is assigned twice in a step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdv(input logic [3:0] a, output logic [15:0] v);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
		@(posedge clk);
	endtask
	// Start a routine, wait for done, then check status, capture and accumulator
	task automatic run(input logic [15:0] start, input logic [15:0] st,
			input logic [15:0] cap, input logic [39:0] acc);
		int k;
		wr(`PMAC_REG_START, start);
		wr(`PMAC_REG_CTRL, 16'h0001);
		k = 0;
		status = 16'h0000;
		while (status[0] !== 1'b1 && k < 40) begin
			rdv(`PMAC_REG_STATUS, status);
			k++;
		end
		chk16(status, st);
		rdv(`PMAC_REG_CAPTURE, status);
		chk16(status, cap);
		chk40(accum, acc);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk16({15'h0000, memHostSel}, 16'h0001);
		rdv(`PMAC_REG_STATUS, status);
		chk16(status, 16'h0000);
		rdv(4'hf, status);
		chk16(status, 16'h0000);
		for (int i = 0; i < 27; i++) begin
			wr(`PMAC_REG_START, 16'(i));
			wr(`PMAC_REG_ROM, image[i]);
		end
		wr(`PMAC_REG_DATA_ADDR, 16'h0012);
		// Data address steps after the first multiply, so the second operand pair differs
		prod = 40'h1205 * 40'h1205 + 40'h1305 * 40'h1305;
		run(16'h0000, 16'h0001, prod[31:16], prod);
		run(16'h0008, 16'h0001, prod[31:16], 40'h0);
		run(16'h0011, 16'h0001, 16'h1305, 40'h0000001305);
		run(16'h000e, 16'h0003, 16'h7fff, 40'h0500001305);
		chk16({15'h0000, memHostSel}, 16'h0000);
		rdv(`PMAC_REG_DATA_ADDR, status);
		chk16(status, 16'h0013);
		rdv(`PMAC_REG_RUNLEN, status);
		chk16(status, 16'h0003);
		// A low clock enable must swallow a host write
		clkEn <= 1'b0;
		wr(`PMAC_REG_START, 16'h0055);
		clkEn <= 1'b1;
		rdv(`PMAC_REG_START, status);
		chk16(status, 16'h000e);
		report_and_stop();
	end
endmodule // pmac_tb_top
